// file: mrp_pkg.sv
// Constants and carrier types for the management and reconfiguration ports
package mrp_pkg;
    localparam int MGMT_ADDR_W    = 16;
    localparam int DATA_W         = 32;
    localparam int MGMT_IDX_W     = 4;
    localparam int MGMT_WORDS     = 16;
    // channel_select_width_param for a four-channel build
    localparam int CHAN_SEL_W     = 2;
    localparam int PCS_OFS_W      = 11;
    localparam int XCVR_ADDR_W    = CHAN_SEL_W + PCS_OFS_W;
    localparam int XCVR_CHANNELS  = 4;
    localparam int PCS_IDX_W      = 3;
    localparam int PCS_WORDS      = 8;
    localparam int PCS_STORE      = XCVR_CHANNELS * PCS_WORDS;
    localparam int STORE_IDX_W    = CHAN_SEL_W + PCS_IDX_W;
    // Cycles a reconfiguration read keeps busy high
    localparam logic [1:0] XCVR_READ_LAT = 2'h2;
    localparam logic [31:0] REG_RST_VAL  = 32'h0;

    typedef logic [DATA_W-1:0] mrp_word_t;

    typedef struct packed {
        logic                   read;
        logic                   write;
        logic [MGMT_ADDR_W-1:0] addr;
        mrp_word_t              wdata;
    } mrp_mgmt_req_s;

    typedef struct packed {
        logic                   read;
        logic                   write;
        logic [XCVR_ADDR_W-1:0] addr;
        mrp_word_t              wdata;
    } mrp_xcvr_req_s;

    typedef enum logic [1:0] {
        MRP_RD_IDLE = 2'b00,
        MRP_RD_WAIT = 2'b01,
        MRP_RD_DONE = 2'b11
    } mrp_rd_state_e;
endpackage

// file: mrp_ports.sv
// Management register bank and transceiver reconfiguration port
`timescale 1ns/10ps
module mrp_ports (
    // Clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             arst_n,
    // Management port
    input  wire mrp_pkg::mrp_mgmt_req_s           mgmt_req,
    output logic [mrp_pkg::DATA_W-1:0]            mgmt_read_result,
    output logic                                  mgmt_read_result_valid,
    // Reconfiguration port
    input  wire logic                             xcvr_cfg_reset,
    input  wire mrp_pkg::mrp_xcvr_req_s           xcvr_req,
    output logic [mrp_pkg::DATA_W-1:0]            xcvr_cfg_read_data,
    output logic                                  xcvr_cfg_busy
);
    import mrp_pkg::*;

    logic [DATA_W-1:0]  mgmt_mem_reg [MGMT_WORDS];
    logic [DATA_W-1:0]  pcs_mem_reg  [PCS_STORE];
    logic [DATA_W-1:0]  mgmt_rdata_reg;
    logic               mgmt_valid_reg;
    logic [DATA_W-1:0]  xcvr_rdata_reg;
    mrp_rd_state_e      rd_state_reg;
    mrp_rd_state_e      rd_state_next;
    logic [1:0]         wait_cnt_reg;
    logic [1:0]         wait_cnt_next;
    logic               xcvr_done;

    // Management address hits the bank only in its low window
    function automatic logic mgmt_hit(input logic [MGMT_ADDR_W-1:0] a);
        mgmt_hit = (a[MGMT_ADDR_W-1:MGMT_IDX_W] == '0);
    endfunction

    // Channel and offset into one flat store index
    function automatic logic [STORE_IDX_W-1:0] pcs_idx(input logic [XCVR_ADDR_W-1:0] a);
        pcs_idx = {a[XCVR_ADDR_W-1:PCS_OFS_W], a[PCS_IDX_W-1:0]};
    endfunction

    // Offset bits above the implemented words are unmapped
    function automatic logic pcs_hit(input logic [XCVR_ADDR_W-1:0] a);
        pcs_hit = (a[PCS_OFS_W-1:PCS_IDX_W] == '0);
    endfunction

    // Management writes, timed by the core clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < MGMT_WORDS; i++) begin
                mgmt_mem_reg[i] <= REG_RST_VAL;
            end
        end else if (mgmt_req.write && mgmt_hit(mgmt_req.addr)) begin
            mgmt_mem_reg[mgmt_req.addr[MGMT_IDX_W-1:0]] <= mgmt_req.wdata;
        end
    end

    // Management read result, one cycle after the strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmt_rdata_reg <= REG_RST_VAL;
            mgmt_valid_reg <= 1'b0;
        end else begin
            mgmt_valid_reg <= mgmt_req.read;
            if (mgmt_req.read) begin
                mgmt_rdata_reg <= mgmt_hit(mgmt_req.addr) ?
                    mgmt_mem_reg[mgmt_req.addr[MGMT_IDX_W-1:0]] : REG_RST_VAL;
            end
        end
    end

    assign mgmt_read_result       = mgmt_rdata_reg;
    assign mgmt_read_result_valid = mgmt_valid_reg;

    // Read wait sequencing; writes finish at once
    always_comb begin
        rd_state_next = rd_state_reg;
        wait_cnt_next = wait_cnt_reg;
        case (rd_state_reg)
            MRP_RD_IDLE: begin
                if (xcvr_req.read) begin
                    rd_state_next = MRP_RD_WAIT;
                    wait_cnt_next = 2'h1;
                end
            end
            MRP_RD_WAIT: begin
                if (!xcvr_req.read) begin
                    rd_state_next = MRP_RD_IDLE;
                    wait_cnt_next = 2'h0;
                end else if (wait_cnt_reg == XCVR_READ_LAT - 2'h1) begin
                    rd_state_next = MRP_RD_DONE;
                    wait_cnt_next = XCVR_READ_LAT;
                end else begin
                    wait_cnt_next = wait_cnt_reg + 2'h1;
                end
            end
            MRP_RD_DONE: begin
                rd_state_next = MRP_RD_IDLE;
                wait_cnt_next = 2'h0;
            end
            default: begin
                rd_state_next = MRP_RD_IDLE;
                wait_cnt_next = 2'h0;
            end
        endcase
    end

    // Sequencer state, cleared by either reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_state_reg <= MRP_RD_IDLE;
            wait_cnt_reg <= 2'h0;
        end else if (xcvr_cfg_reset) begin
            rd_state_reg <= MRP_RD_IDLE;
            wait_cnt_reg <= 2'h0;
        end else begin
            rd_state_reg <= rd_state_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    // Busy while a read has not reached its data cycle
    assign xcvr_cfg_busy = xcvr_req.read && (rd_state_reg != MRP_RD_DONE);
    assign xcvr_done     = !xcvr_cfg_busy;

    // PCS store, indexed by channel and offset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < PCS_STORE; i++) begin
                pcs_mem_reg[i] <= REG_RST_VAL;
            end
        end else if (xcvr_cfg_reset) begin
            for (int i = 0; i < PCS_STORE; i++) begin
                pcs_mem_reg[i] <= REG_RST_VAL;
            end
        end else if (xcvr_req.write && !xcvr_req.read && xcvr_done && pcs_hit(xcvr_req.addr)) begin
            pcs_mem_reg[pcs_idx(xcvr_req.addr)] <= xcvr_req.wdata;
        end
    end

    // Read data captured in the last busy cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            xcvr_rdata_reg <= REG_RST_VAL;
        end else if (xcvr_cfg_reset) begin
            xcvr_rdata_reg <= REG_RST_VAL;
        end else if (xcvr_req.read && rd_state_next == MRP_RD_DONE) begin
            xcvr_rdata_reg <= pcs_hit(xcvr_req.addr) ?
                pcs_mem_reg[pcs_idx(xcvr_req.addr)] : REG_RST_VAL;
        end
    end

    assign xcvr_cfg_read_data = xcvr_rdata_reg;

    // Assertions
    property p_mgmt_valid_after_read;
        @(posedge core_clk) disable iff (!arst_n)
        mgmt_req.read |=> mgmt_read_result_valid;
    endproperty
    a_mgmt_valid_after_read: assert property (p_mgmt_valid_after_read)
        else $error("management read gave no valid pulse");

    property p_mgmt_valid_has_cause;
        @(posedge core_clk) disable iff (!arst_n)
        mgmt_read_result_valid |-> $past(mgmt_req.read);
    endproperty
    a_mgmt_valid_has_cause: assert property (p_mgmt_valid_has_cause)
        else $error("management valid without a read");

    property p_mgmt_write_readback;
        @(posedge core_clk) disable iff (!arst_n)
        (mgmt_req.write && mgmt_hit(mgmt_req.addr))
            ##1 (mgmt_req.read && !mgmt_req.write && mgmt_req.addr == $past(mgmt_req.addr))
            |=> mgmt_read_result == $past(mgmt_req.wdata, 2);
    endproperty
    a_mgmt_write_readback: assert property (p_mgmt_write_readback)
        else $error("management readback mismatch");

    property p_mgmt_unmapped_zero;
        @(posedge core_clk) disable iff (!arst_n)
        (mgmt_req.read && !mgmt_hit(mgmt_req.addr)) |=> mgmt_read_result == REG_RST_VAL;
    endproperty
    a_mgmt_unmapped_zero: assert property (p_mgmt_unmapped_zero)
        else $error("unmapped management read not zero");

    property p_xcvr_busy_span;
        @(posedge core_clk) disable iff (!arst_n || xcvr_cfg_reset)
        ($rose(xcvr_req.read) && rd_state_reg == MRP_RD_IDLE) ##0 xcvr_req.read [*3]
            |-> $past(xcvr_cfg_busy, 2) && $past(xcvr_cfg_busy) && !xcvr_cfg_busy;
    endproperty
    a_xcvr_busy_span: assert property (p_xcvr_busy_span)
        else $error("reconfiguration busy span wrong");

    property p_xcvr_write_no_wait;
        @(posedge core_clk) disable iff (!arst_n)
        (xcvr_req.write && !xcvr_req.read) |-> !xcvr_cfg_busy;
    endproperty
    a_xcvr_write_no_wait: assert property (p_xcvr_write_no_wait)
        else $error("reconfiguration write stalled");

    property p_xcvr_write_lands;
        @(posedge core_clk) disable iff (!arst_n || xcvr_cfg_reset)
        (xcvr_req.write && !xcvr_req.read && pcs_hit(xcvr_req.addr))
            |=> pcs_mem_reg[$past(pcs_idx(xcvr_req.addr))] == $past(xcvr_req.wdata);
    endproperty
    a_xcvr_write_lands: assert property (p_xcvr_write_lands)
        else $error("reconfiguration write did not land");

    property p_xcvr_write_readback;
        @(posedge core_clk) disable iff (!arst_n || xcvr_cfg_reset)
        (xcvr_req.write && !xcvr_req.read && pcs_hit(xcvr_req.addr))
            ##1 ($rose(xcvr_req.read) && !xcvr_req.write
                 && xcvr_req.addr == $past(xcvr_req.addr))
            ##0 (xcvr_req.read && !xcvr_req.write) [*3]
            |-> !xcvr_cfg_busy && xcvr_cfg_read_data == $past(xcvr_req.wdata, 3);
    endproperty
    a_xcvr_write_readback: assert property (p_xcvr_write_readback)
        else $error("reconfiguration readback mismatch");

    property p_xcvr_reset_clears;
        @(posedge core_clk) disable iff (!arst_n)
        xcvr_cfg_reset |=> rd_state_reg == MRP_RD_IDLE && xcvr_cfg_read_data == REG_RST_VAL;
    endproperty
    a_xcvr_reset_clears: assert property (p_xcvr_reset_clears)
        else $error("reconfiguration reset did not clear");

    c_mgmt_read: cover property (@(posedge core_clk) disable iff (!arst_n)
        mgmt_req.read ##1 mgmt_read_result_valid);
    c_mgmt_back_to_back: cover property (@(posedge core_clk) disable iff (!arst_n)
        mgmt_req.read [*2] ##1 mgmt_read_result_valid);
    c_xcvr_read_done: cover property (@(posedge core_clk) disable iff (!arst_n)
        xcvr_cfg_busy ##1 (xcvr_req.read && !xcvr_cfg_busy));
    c_xcvr_write: cover property (@(posedge core_clk) disable iff (!arst_n)
        xcvr_req.write && !xcvr_cfg_busy);
endmodule

// file: mrp_host_model.sv
// Host-side model driving the reconfiguration port
`timescale 1ns/10ps
module mrp_host_model (
    // Clock
    input  wire logic                       core_clk,
    // Reconfiguration requests
    output mrp_pkg::mrp_xcvr_req_s          xcvr_req,
    output logic                            xcvr_cfg_reset,
    // Reconfiguration answers
    input  wire logic                       xcvr_cfg_busy,
    input  wire logic [mrp_pkg::DATA_W-1:0] xcvr_cfg_read_data
);
    import mrp_pkg::*;

    // Idle request at time zero
    initial begin
        xcvr_req       = '{1'b0, 1'b0, '1, '1};
        xcvr_cfg_reset = 1'b0;
    end

    // Release request lines, leave the old values no longer showing
    task automatic xcvr_idle();
        xcvr_req = '{1'b0, 1'b0, ~xcvr_req.addr, ~xcvr_req.wdata};
        @(negedge core_clk);
    endtask

    // One write cycle; reports busy seen while it stands
    task automatic xcvr_wr(input logic [XCVR_ADDR_W-1:0] a, input mrp_word_t d, output logic b);
        xcvr_req = '{1'b0, 1'b1, a, d};
        #1;
        b = xcvr_cfg_busy;
        @(negedge core_clk);
    endtask

    // Read held until busy drops, or dropped early after lim busy cycles
    task automatic xcvr_rd(input logic [XCVR_ADDR_W-1:0] a, input int lim,
                           output mrp_word_t d, output int n);
        n = 0;
        xcvr_req = '{1'b1, 1'b0, a, ~xcvr_req.wdata};
        #1;
        while (xcvr_cfg_busy !== 1'b0 && n < lim) begin
            n++;
            @(negedge core_clk);
        end
        d = xcvr_cfg_read_data;
        if (n < lim) begin
            @(negedge core_clk);
        end
        xcvr_idle();
    endtask

    // One-cycle synchronous reset pulse of the port
    task automatic xcvr_rst();
        xcvr_cfg_reset = 1'b1;
        @(negedge core_clk);
        xcvr_cfg_reset = 1'b0;
        @(negedge core_clk);
    endtask
endmodule

// file: testbench.sv
// Self-checking testbench for the management and reconfiguration ports
`timescale 1ns/10ps
module testbench;
    import mrp_pkg::*;
    logic          core_clk = 1'b0;
    logic          arst_n   = 1'b0;
    mrp_mgmt_req_s mgmt_req = '{1'b0, 1'b0, '1, '1};
    mrp_xcvr_req_s xcvr_req;
    logic          xcvr_cfg_reset;
    mrp_word_t     mgmt_read_result;
    logic          mgmt_read_result_valid;
    mrp_word_t     xcvr_cfg_read_data;
    logic          xcvr_cfg_busy;
    int            failures = 0;
    int            n_tests  = 0;

    // 40 MHz bench clock; the block itself does not depend on the rate
    always #12.5 core_clk = ~core_clk;

    mrp_ports u_mrp_ports (.core_clk(core_clk), .arst_n(arst_n), .mgmt_req(mgmt_req),
        .mgmt_read_result(mgmt_read_result), .mgmt_read_result_valid(mgmt_read_result_valid),
        .xcvr_cfg_reset(xcvr_cfg_reset), .xcvr_req(xcvr_req),
        .xcvr_cfg_read_data(xcvr_cfg_read_data), .xcvr_cfg_busy(xcvr_cfg_busy));
    mrp_host_model u_mrp_host_model (.core_clk(core_clk), .xcvr_req(xcvr_req),
        .xcvr_cfg_reset(xcvr_cfg_reset), .xcvr_cfg_busy(xcvr_cfg_busy),
        .xcvr_cfg_read_data(xcvr_cfg_read_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One management cycle presented at a falling edge
    task automatic mgmt_cycle(input logic r, input logic w, input int a, input mrp_word_t d);
        mgmt_req = '{r, w, a[15:0], d};
        @(negedge core_clk);
    endtask

    // Full reconfiguration read with busy count and data compare
    task automatic xread(input int ch, input int o, input mrp_word_t exp);
        mrp_word_t d;
        int        n;
        u_mrp_host_model.xcvr_rd({ch[1:0], o[10:0]}, 8, d, n);
        check(32'(n), 32'h2);
        check(d, exp);
        if (n >= 8) begin
            tally_and_finish();
        end
    endtask

    // Outputs quiet under reset, then release
    task automatic test_reset();
        repeat (12) @(negedge core_clk);
        check(mgmt_read_result_valid, 1'b0);
        check(xcvr_cfg_busy, 1'b0);
        arst_n = 1'b1;
        @(negedge core_clk);
    endtask

    // Back-to-back writes and reads, collisions and unmapped places
    task automatic test_mgmt();
        for (int i = 0; i < 16; i++) mgmt_cycle(1'b0, 1'b1, i, 32'ha5c3_0000 | i);
        for (int i = 0; i < 16; i++) begin
            mgmt_cycle(1'b1, 1'b0, i, 32'h0);
            check(mgmt_read_result_valid, 1'b1);
            check(mgmt_read_result, 32'ha5c3_0000 | i);
        end
        mgmt_cycle(1'b1, 1'b1, 3, 32'h0bad_f00d);
        check(mgmt_read_result, 32'ha5c3_0003);
        mgmt_cycle(1'b1, 1'b0, 3, 32'h0);
        check(mgmt_read_result, 32'h0bad_f00d);
        mgmt_cycle(1'b0, 1'b1, 16'h0015, 32'hffff_ffff);
        mgmt_cycle(1'b1, 1'b0, 16'h0013, 32'h0);
        check(mgmt_read_result, 32'h0);
        mgmt_cycle(1'b1, 1'b0, 5, 32'h0);
        check(mgmt_read_result, 32'ha5c3_0005);
        mgmt_cycle(1'b0, 1'b0, 16'hfff0, 32'h5a5a_5a5a);
        check(mgmt_read_result_valid, 1'b0);
        check(mgmt_read_result, 32'ha5c3_0005);
    endtask

    // Boundary offsets on every channel, written back to back then read
    task automatic test_xcvr();
        logic b;
        for (int ch = 0; ch < 4; ch++) for (int o = 0; o < 8; o += 7) begin
            u_mrp_host_model.xcvr_wr({ch[1:0], o[10:0]}, 32'h5a00_0000 | (ch << 8) | o, b);
            check(b, 1'b0);
        end
        u_mrp_host_model.xcvr_idle();
        for (int ch = 0; ch < 4; ch++) for (int o = 0; o < 8; o += 7) begin
            xread(ch, o, 32'h5a00_0000 | (ch << 8) | o);
        end
    endtask

    // Read dropped in mid-wait, then a full read must wait again
    task automatic test_abort();
        mrp_word_t d;
        int        n;
        u_mrp_host_model.xcvr_rd({2'h2, 11'h7}, 1, d, n);
        check(xcvr_cfg_busy, 1'b0);
        xread(2, 7, 32'h5a00_0207);
    endtask

    // Port reset clears the store but spares the management bank
    task automatic test_cfg_reset();
        logic b;
        u_mrp_host_model.xcvr_rst();
        xread(1, 0, 32'h0);
        u_mrp_host_model.xcvr_wr({2'h3, 11'h004}, 32'h3c3c_0304, b);
        check(b, 1'b0);
        xread(3, 4, 32'h3c3c_0304);
        u_mrp_host_model.xcvr_wr({2'h3, 11'h00c}, 32'hffff_ffff, b);
        check(b, 1'b0);
        xread(3, 4, 32'h3c3c_0304);
        xread(3, 12, 32'h0);
        mgmt_cycle(1'b1, 1'b0, 3, 32'h0);
        check(mgmt_read_result, 32'h0bad_f00d);
        mgmt_cycle(1'b0, 1'b0, 16'h000f, 32'hffff_fffe);
    endtask

    // Main sequence
    initial begin
        test_reset();
        test_mgmt();
        test_xcvr();
        test_abort();
        test_cfg_reset();
        tally_and_finish();
    end
endmodule
